// ---- design/kwdt_pkg.sv ----
`default_nettype none
package kwdt_pkg;
   // Register byte offsets
   localparam logic [3:0] KWDT_OFS_OVERFLOW_MODE = 4'h0;
   localparam logic [3:0] KWDT_OFS_TICK_MODE = 4'h4;
   localparam logic [3:0] KWDT_OFS_RESTART = 4'h8;
   localparam logic [3:0] KWDT_OFS_STATUS = 4'hC;
   localparam logic [3:0] KWDT_OFS_IRQ_STATUS = 4'h0;
   localparam logic [3:0] KWDT_OFS_IRQ_MASK = 4'h4;
   // Second page of registers (address bit 4)
   localparam int KWDT_PAGE_BIT = 4;
   // Keys
   localparam logic [11:0] KWDT_OVERFLOW_KEY = 12'h234;
   localparam logic [8:0] KWDT_TICK_KEY = 9'h06E;
   localparam logic [15:0] KWDT_RESTART_KEY = 16'hC071;
   // Field positions
   localparam int KWDT_OVERFLOW_MODE_KEY_LSB = 4;
   localparam int KWDT_TICK_MODE_KEY_LSB = 7;
   localparam int KWDT_HPN_LSB = 2;
   // Counter shape
   localparam int KWDT_CNT_W = 16;
   localparam logic [11:0] KWDT_LOW_PRELOAD = 12'hFFF;
   // Tick dividers
   localparam int KWDT_DIV0 = 8;
   localparam int KWDT_DIV1 = 32;
   localparam int KWDT_DIV2 = 128;
   localparam int KWDT_DIV3 = 1024;
   localparam int KWDT_PRESC_W = 10;
   // External pulse length in master clock cycles
   localparam int KWDT_EXT_CYCLES = 8;
   localparam logic [3:0] KWDT_EXT_CNT_INIT = 4'(KWDT_EXT_CYCLES);

   // Overflow mode fields
   typedef struct packed {
      logic ext_pulse_en;
      logic irq_on_overflow_en;
      logic reset_on_overflow_en;
      logic watchdog_on;
   } kwdt_omode_type;

   // Tick and preload mode fields
   typedef struct packed {
      logic [3:0] high_preload_nibble;
      logic [1:0] tick_source_select;
   } kwdt_cmode_type;

   // Decoded APB write request
   typedef struct packed {
      logic wr;
      logic [3:0] ofs;
      logic page;
      logic [31:0] data;
   } kwdt_wreq_type;
endpackage
`default_nettype wire

// ---- design/kwdt_ticker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Prescaler: gives one tick pulse at the selected division of the clock
module kwdt_ticker
   import kwdt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [1:0] sel,
   output logic tick
);
   logic [KWDT_PRESC_W-1:0] presc_r;
   logic [KWDT_PRESC_W-1:0] presc_nxt;
   logic [KWDT_PRESC_W-1:0] limit;

   // Division select
   function automatic logic [KWDT_PRESC_W-1:0] div_limit(input logic [1:0] s);
      case (s)
         2'h0: div_limit = KWDT_PRESC_W'(KWDT_DIV0 - 1);
         2'h1: div_limit = KWDT_PRESC_W'(KWDT_DIV1 - 1);
         2'h2: div_limit = KWDT_PRESC_W'(KWDT_DIV2 - 1);
         default: div_limit = KWDT_PRESC_W'(KWDT_DIV3 - 1);
      endcase
   endfunction

   // Count up to the limit; held at zero while stopped
   always_comb begin
      limit = div_limit(sel); // [R6]
      tick = run && (presc_r >= limit);
      if (!run || presc_r >= limit) begin
         presc_nxt = '0;
      end else begin
         presc_nxt = presc_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         presc_r <= '0;
      end else begin
         presc_r <= presc_nxt;
      end
   end
endmodule // kwdt_ticker
`default_nettype wire

// ---- design/kwdt_top.sv ----
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// R1 - Overflow with reset enable requests reset
// R2 - Overflow with irq enable pulses irq
// R3 - Overflow with ext enable: pin low 8 cycles
// R4 - Sixteen-bit down counter
// R5 - Restart loads nibble then FFF
// R6 - Tick rate from select: 8/32/128/1024
// R7 - Overflow mode write needs key 0x234
// R8 - Tick mode write needs key 0x06E
// R9 - Software sends key and bits together
// R10 - Only 0xC071 restarts the counter
// R11 - Disabled watchdog gives no outputs; here a restart still sets its event and can raise irq
// R12 - Modes and status zero after reset
// R13 - Overflow flag set, cleared by restart
// R14 - Count per tick, overflow once per restart
module kwdt_top
   import kwdt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic internal_reset_req,
   output logic overflow_irq,
   output logic overflow_out_n,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   kwdt_omode_type omode_r, omode_nxt; // Overflow mode bits
   kwdt_cmode_type cmode_r, cmode_nxt; // Tick and preload bits
   logic [KWDT_CNT_W-1:0] cnt_r, cnt_nxt; // Down counter [R4]
   logic ovf_flag_r, ovf_flag_nxt; // Overflow status
   logic armed_r, armed_nxt; // Cleared after overflow until restart
   logic [3:0] ext_cnt_r, ext_cnt_nxt; // External pulse length
   logic rst_req_r, rst_req_nxt; // Reset request, held
   logic irq_pulse_r, irq_pulse_nxt; // One-cycle irq pulse
   logic [1:0] ev_stat_r, ev_stat_nxt; // Sticky events: 0 overflow, 1 restart
   logic [1:0] ev_mask_r, ev_mask_nxt; // Event mask
   logic [31:0] rdata_r, rdata_nxt; // Read data register
   logic tick; // Counter decrement strobe
   logic restart; // Valid restart write
   logic ovf_event; // Counter passed zero
   kwdt_wreq_type wreq; // Decoded write
   logic access; // APB access phase
   logic unmapped; // Address outside map

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states
   assign access = psel && penable;
   assign pready = 1'b1;
   always_comb begin
      wreq.wr = access && pwrite;
      wreq.ofs = paddr[3:0];
      wreq.page = paddr[KWDT_PAGE_BIT];
      wreq.data = pwdata;
      // Only words 0..5 exist; the second page has two
      unmapped = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0)
         || (paddr[KWDT_PAGE_BIT] && paddr[3]);
   end
   assign pslverr = access && unmapped;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler runs only while enabled and armed, so ticks align to a restart that follows an overflow
   kwdt_ticker u_ticker (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(omode_r.watchdog_on && armed_r),
      .sel(cmode_r.tick_source_select),
      .tick(tick)
   );

   // Restart needs the exact key in the low half
   assign restart = wreq.wr && !unmapped && !wreq.page && wreq.ofs == KWDT_OFS_RESTART
      && wreq.data[15:0] == KWDT_RESTART_KEY; // [R10]
   assign ovf_event = tick && cnt_r == '0; // [R14]

   ////////////////////////////////////////////////////////////////////////////
   // Mode registers
   always_comb begin
      omode_nxt = omode_r;
      cmode_nxt = cmode_r;
      ev_mask_nxt = ev_mask_r;
      if (wreq.wr && !unmapped && !wreq.page) begin
         // Key and bits must arrive in one write [R9]
         if (wreq.ofs == KWDT_OFS_OVERFLOW_MODE
            && wreq.data[15:KWDT_OVERFLOW_MODE_KEY_LSB] == KWDT_OVERFLOW_KEY) begin // [R7]
            omode_nxt = wreq.data[3:0];
         end
         if (wreq.ofs == KWDT_OFS_TICK_MODE
            && wreq.data[15:KWDT_TICK_MODE_KEY_LSB] == KWDT_TICK_KEY) begin // [R8]
            cmode_nxt = wreq.data[KWDT_HPN_LSB+3:0];
         end
      end
      if (wreq.wr && !unmapped && wreq.page && wreq.ofs == KWDT_OFS_IRQ_MASK) begin
         ev_mask_nxt = wreq.data[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, flag and overflow outputs
   always_comb begin
      cnt_nxt = cnt_r;
      armed_nxt = armed_r;
      ovf_flag_nxt = ovf_flag_r;
      ext_cnt_nxt = ext_cnt_r;
      rst_req_nxt = rst_req_r;
      irq_pulse_nxt = 1'b0;
      if (restart) begin
         cnt_nxt = {cmode_r.high_preload_nibble, KWDT_LOW_PRELOAD}; // [R5]
         armed_nxt = 1'b1;
         ovf_flag_nxt = 1'b0; // [R13]
      end else if (ovf_event) begin
         // Wrap but stop: one overflow per restart
         cnt_nxt = cnt_r - 1'b1; // [R14]
         armed_nxt = 1'b0;
         ovf_flag_nxt = 1'b1; // [R13]
         // Enable already gates the ticker [R11]
         if (omode_r.reset_on_overflow_en) begin
            rst_req_nxt = 1'b1; // [R1]
         end
         if (omode_r.irq_on_overflow_en) begin
            irq_pulse_nxt = 1'b1; // [R2]
         end
         if (omode_r.ext_pulse_en) begin
            ext_cnt_nxt = KWDT_EXT_CNT_INIT; // [R3]
         end
      end else if (tick) begin
         cnt_nxt = cnt_r - 1'b1; // [R4]
      end
      if (!ovf_event && ext_cnt_r != 4'h0) begin
         ext_cnt_nxt = ext_cnt_r - 1'b1; // [R3]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events, set wins over write-one clear
   always_comb begin
      ev_stat_nxt = ev_stat_r;
      if (wreq.wr && !unmapped && wreq.page && wreq.ofs == KWDT_OFS_IRQ_STATUS) begin
         ev_stat_nxt = ev_stat_r & ~wreq.data[1:0];
      end
      if (ovf_event) begin
         ev_stat_nxt[0] = 1'b1;
      end
      if (restart) begin
         ev_stat_nxt[1] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; keys read as zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (psel && !penable && !pwrite) begin
         rdata_nxt = '0;
         if (!paddr[KWDT_PAGE_BIT]) begin
            case (paddr[3:0])
               KWDT_OFS_OVERFLOW_MODE: rdata_nxt[3:0] = omode_r; // [R7]
               KWDT_OFS_TICK_MODE: rdata_nxt[KWDT_HPN_LSB+3:0] = cmode_r; // [R8]
               KWDT_OFS_STATUS: rdata_nxt[0] = ovf_flag_r; // [R13]
               default: rdata_nxt = '0;
            endcase
         end else begin
            case (paddr[3:0])
               KWDT_OFS_IRQ_STATUS: rdata_nxt[1:0] = ev_stat_r;
               KWDT_OFS_IRQ_MASK: rdata_nxt[1:0] = ev_mask_r;
               default: rdata_nxt = '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         omode_r <= '0; // [R12]
         cmode_r <= '0; // [R12]
         ovf_flag_r <= 1'b0; // [R12]
         cnt_r <= '0;
         armed_r <= 1'b1;
         ext_cnt_r <= 4'h0;
         rst_req_r <= 1'b0;
         irq_pulse_r <= 1'b0;
         ev_stat_r <= 2'h0;
         ev_mask_r <= 2'h0;
         rdata_r <= '0;
      end else begin
         omode_r <= omode_nxt;
         cmode_r <= cmode_nxt;
         ovf_flag_r <= ovf_flag_nxt;
         cnt_r <= cnt_nxt;
         armed_r <= armed_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         rst_req_r <= rst_req_nxt;
         irq_pulse_r <= irq_pulse_nxt;
         ev_stat_r <= ev_stat_nxt;
         ev_mask_r <= ev_mask_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Read data, reset request and irq pulse from flip-flops, pin and irq decoded from them; reset request holds until system reset
   assign prdata = rdata_r;
   assign internal_reset_req = rst_req_r; // [R1]
   assign overflow_irq = irq_pulse_r; // [R2]
   assign overflow_out_n = (ext_cnt_r == 4'h0); // [R3]
   assign irq = |(ev_stat_r & ev_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_ovf_ext;
      ovf_event && omode_r.ext_pulse_en;
   endsequence

   // Keyed writes that must land on the next edge
   sequence s_overflow_mode_key_wr;
      wreq.wr && paddr == 8'h00 && pwdata[15:4] == 12'h234;
   endsequence
   sequence s_tick_mode_key_wr;
      wreq.wr && paddr == 8'h04 && pwdata[15:7] == 9'h06E;
   endsequence

   a_ext_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
      s_ovf_ext |=> !overflow_out_n [*8] ##1 overflow_out_n)
      else $error("external pulse not eight cycles");
   a_irq_single: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
      overflow_irq |=> !overflow_irq)
      else $error("irq pulse longer than one cycle");
   a_irq_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
      $rose(overflow_irq) |-> $past(ovf_event) && $past(omode_r.irq_on_overflow_en))
      else $error("irq without enabled overflow");
   a_reset_req: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
      ovf_event && omode_r.reset_on_overflow_en |=> internal_reset_req)
      else $error("reset request missing");
   a_preload_val: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
      restart |=> cnt_r == {$past(cmode_r.high_preload_nibble), 12'hFFF})
      else $error("wrong preload");
   a_overflow_mode_key_guard: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
      wreq.wr && paddr == 8'h00 && pwdata[15:4] != 12'h234 |=> $stable(omode_r))
      else $error("overflow mode written without key");
   a_tick_mode_key_guard: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
      wreq.wr && paddr == 8'h04 && pwdata[15:7] != 9'h06E |=> $stable(cmode_r))
      else $error("tick mode written without key");
   a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
      !omode_r.watchdog_on |=> !overflow_irq && !$rose(internal_reset_req)
         && !$fell(overflow_out_n))
      else $error("overflow output while disabled");
   a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
      ovf_event && !restart |=> ovf_flag_r ##0 ev_stat_r[0])
      else $error("overflow flag not set");
   a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      tick && !restart && cnt_r != 16'h0 |=> cnt_r == $past(cnt_r) - 16'h1)
      else $error("counter step wrong");
   a_once_only: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      ovf_event |=> !armed_r until restart)
      else $error("rearmed without restart");
   a_reset_zero: assert property (@(posedge ref_clk) // [R12]
      !rst_n |=> omode_r == '0 && cmode_r == '0 && !ovf_flag_r)
      else $error("modes not zero after reset");
   a_restart_key: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
      wreq.wr && paddr == 8'h08 && pwdata[15:0] != 16'hC071 |-> !restart)
      else $error("restart without key");

   // A correct key must carry the new bits in the same write
   a_omode_take: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
      s_overflow_mode_key_wr |=> omode_r == $past(pwdata[3:0]))
      else $error("keyed overflow mode write lost");
   a_cmode_take: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
      s_tick_mode_key_wr |=> cmode_r == $past(pwdata[5:0]))
      else $error("keyed tick mode write lost");

   // Flag, request and pin only move for their own causes
   a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
      restart |=> !ovf_flag_r)
      else $error("overflow flag not cleared by restart");
   a_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
      ovf_flag_r && !restart |=> ovf_flag_r)
      else $error("overflow flag lost without restart");
   // The request is a level; only system reset may take it away
   a_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
      internal_reset_req |=> internal_reset_req)
      else $error("reset request dropped");
   a_ext_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
      $fell(overflow_out_n) |-> $past(ovf_event && omode_r.ext_pulse_en))
      else $error("pin pulse without enabled overflow");

   // Smallest division is eight, so ticks never come back to back
   a_ticks_run: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
      tick |=> !tick)
      else $error("ticks back to back");

   // One overflow per restart, then the count freezes
   a_restart_arm: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      restart |=> armed_r)
      else $error("restart did not rearm");
   a_halt_after: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      !armed_r && !restart |=> $stable(cnt_r))
      else $error("counter moved after overflow");
endmodule // kwdt_top
`default_nettype wire

// ---- tb/kwdt_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side: interrupt controller, reset logic and a watcher on the pin
module kwdt_partner
   import kwdt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic overflow_irq,
   input wire logic overflow_out_n,
   input wire logic internal_reset_req,
   output var int pulses,
   output var int low_len,
   output var logic rst_seen
);
   int run_len; // Length of the current low stretch
   // Sampled at the edge, so a one-cycle pulse counts exactly once
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         pulses <= 0;
         low_len <= 0;
         run_len <= 0;
         rst_seen <= 1'b0;
      end else begin
         if (overflow_irq === 1'b1) pulses <= pulses + 1;
         if (overflow_out_n === 1'b0) run_len <= run_len + 1;
         else if (run_len != 0) begin
            low_len <= run_len;
            run_len <= 0;
         end
         if (internal_reset_req === 1'b1) rst_seen <= 1'b1;
      end
   end
endmodule // kwdt_partner
`default_nettype wire

// ---- tb/tb_kwdt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_kwdt_top
   import kwdt_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, internal_reset_req, overflow_irq, overflow_out_n, irq, err, rst_seen;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   int pulses, low_len, n;
   integer seed = 32'h76AA;
   logic [31:0] rnd; // Random draw
   logic [3:0] en; // Overflow outputs enabled in this pass
   int omr_m, cmr_m, st_m, ev_m, mask_m; // Behavioural register model
   int dv[4] = '{8, 32, 128, 1024}; // Tick divisions per select code

   kwdt_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .internal_reset_req(internal_reset_req),
      .overflow_irq(overflow_irq), .overflow_out_n(overflow_out_n), .irq(irq));
   kwdt_partner far_u (.ref_clk(ref_clk), .rst_n(rst_n), .overflow_irq(overflow_irq),
      .overflow_out_n(overflow_out_n), .internal_reset_req(internal_reset_req),
      .pulses(pulses), .low_len(low_len), .rst_seen(rst_seen));

   // 25 MHz clock
   initial forever #20 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Value compare
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got 'h%0h exp 'h%0h", $time, g, e);
      end
   endtask
   // Cycle count compare against a window
   task chk_rng(input int g, input int lo, input int hi);
      checked++;
      if (g < lo || g > hi) begin
         bad_count++;
         $display("BAD t=%0t got 'h%0h exp 'h%0h", $time, g, lo);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Key and control bits always go in one write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == 8'h00 && d[15:4] == 12'h234) omr_m = d[3:0];
      if (a == 8'h04 && d[15:7] == 9'h06E) cmr_m = d[5:0];
      if (a == 8'h08 && d[15:0] == 16'hC071) begin
         st_m = 0;
         ev_m |= 2;
      end
      if (a == 8'h10) ev_m &= ~int'(d[1:0]);
      if (a == 8'h14) mask_m = d[1:0];
   endtask
   // Read and compare with the model; keys and write-only read as zero
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      case (a)
         8'h00: chk(r, omr_m);
         8'h04: chk(r, cmr_m);
         8'h0C: chk(r, st_m);
         8'h10: chk(r, ev_m);
         8'h14: chk(r, mask_m);
         default: chk(r, 32'h0);
      endcase
   endtask
   task dor;
      rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      {omr_m, cmr_m, st_m, ev_m, mask_m} = '0;
   endtask
   // Count settled cycles until the overflow pulse, then log it in the model
   task automatic wait_ovf(input int lo, input int hi);
      n = 0;
      while (overflow_irq !== 1'b1 && n < hi + 4) begin
         @(negedge ref_clk);
         n++;
      end
      chk_rng(n, lo, hi);
      st_m = 1;
      ev_m |= 1;
   endtask

   // Hang guard
   initial forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc > 60000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      dor();
      for (int a = 0; a <= 20; a += 4) rd(8'(a));
      rd(8'h18);
      chk(err, 1'b1);
      wr(8'h00, 32'h2331);
      rd(8'h00);
      wr(8'h00, 32'h234E);
      rd(8'h00);
      repeat (200) @(negedge ref_clk);
      chk(pulses, 0);
      chk(rst_seen, 1'b0);
      chk(low_len, 0);
      rd(8'h0C);
      $display("test keys and disable done");
      for (int s = 0; s < 4; s++) begin
         dor();
         wr(8'h14, (s != 1));
         rnd = $random(seed);
         wr(8'h04, {16'h0, 9'h06E, 1'b0, rnd[3:0], 2'(s)});
         rd(8'h04);
         if (rnd[15:7] == 9'h06E) rnd[7] = ~rnd[7];
         wr(8'h04, rnd);
         rd(8'h04);
         en = (s == 1) ? 4'h7 : ((s == 2) ? 4'h5 : 4'hF);
         wr(8'h00, {16'h0, 12'h234, en});
         wait_ovf(dv[s] + 1, dv[s] + 3);
         repeat (12) @(negedge ref_clk);
         chk(pulses, 1);
         chk(low_len, en[3] ? 8 : 0);
         chk(rst_seen, en[1]);
         chk(irq, (s != 1));
         rd(8'h0C);
         rd(8'h10);
         wr(8'h10, 32'h1);
         repeat (2) @(negedge ref_clk);
         chk(irq, 1'b0);
         wr(8'h08, 32'hC070);
         rd(8'h0C);
         wr(8'h08, 32'hC071);
         rd(8'h0C);
         rd(8'h10);
         $display("test tick select %0d done", s);
      end
      dor();
      wr(8'h04, 32'h3700);
      wr(8'h08, 32'hC071);
      wr(8'h14, 32'h1);
      wr(8'h00, 32'h234F);
      wait_ovf(32769, 32771);
      repeat (100) @(negedge ref_clk);
      chk(pulses, 1);
      rd(8'h0C);
      $display("test full count done");
      stop_test();
   end
endmodule // tb_kwdt_top
`default_nettype wire
